// ### rtl/crr_core_regs.sv
// cpu core register set: accumulator, index registers, pointers, flag word
`timescale 1ns/1ps
module crr_core_regs
	import crr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// operation port from the instruction sequencer
	input wire logic op_valid_i,
	input wire crr_op_e op_code_i,
	input wire crr_sel_e op_sel_i,
	input wire logic [2:0] op_bit_i,
	input wire logic [7:0] op_data_i,
	input wire logic [15:0] op_addr_i,
	input wire logic [1:0] irq_level_i,
	// stack memory port
	output logic [15:0] stk_addr_o,
	output logic [7:0] stk_wdata_o,
	output logic stk_we_o,
	output logic stk_re_o,
	input wire logic [7:0] stk_rdata_i,
	// register contents and status
	output logic [7:0] acc_o,
	output logic [7:0] idx_x_o,
	output logic [7:0] idx_y_o,
	output logic [15:0] instr_pointer_o,
	output logic [7:0] flag_word_o,
	output logic [15:0] stack_ptr_o,
	output logic busy_o
);
	// ---------------------------------------------------------------
	// state record
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] acc; // accumulator
		logic [7:0] idx_x; // first index register
		logic [7:0] idx_y; // second index register
		logic [15:0] ip; // instr_pointer
		logic [15:0] tgt; // jump target after a push sequence
		logic [7:0] flags; // flag_word
		logic [7:0] sp_low; // stack_ptr low byte
		crr_state_e st; // sequencer state
		logic [2:0] slot; // current frame slot
		logic [2:0] last; // final frame slot
		logic fin_ip; // load ip from tgt when pushing ends
		logic fin_prio; // load priority when pushing ends
		logic [1:0] prio; // latched interrupt level
		logic [15:0] stk_addr; // stack memory address
		logic [7:0] stk_wdata; // stack write byte
		logic stk_we; // stack write strobe
		logic stk_re; // stack read strobe
		logic busy; // sequence running
	} crr_regs_s;
	crr_regs_s r_reg; // registered state
	crr_regs_s r_next; // next state
	logic accept; // operation taken this cycle
	logic push_now; // write one byte this cycle
	logic pop_now; // read one byte this cycle
	logic [2:0] slot_go; // slot moved this cycle
	logic [9:0] alu; // {half, carry, result}
	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	// force the fixed flag bits
	function automatic logic [7:0] fix_flags(input logic [7:0] v);
		fix_flags = v | FLAG_FIXED;
	endfunction
	// negative and zero of a result, as {n, z}
	function automatic logic [1:0] nz_of(input logic [7:0] v);
		nz_of = {v[7], v == 8'h00};
	endfunction
	// selector to frame slot
	function automatic logic [2:0] sel_slot(input crr_sel_e s);
		case (s)
			SEL_A: sel_slot = SLOT_A;
			SEL_X: sel_slot = SLOT_X;
			SEL_Y: sel_slot = SLOT_Y;
			default: sel_slot = SLOT_CC;
		endcase
	endfunction
	// byte pushed for a slot
	function automatic logic [7:0] slot_byte(input crr_regs_s s, input logic [2:0] k);
		case (k)
			SLOT_PCL: slot_byte = s.ip[7:0];
			SLOT_PCH: slot_byte = s.ip[15:8];
			SLOT_X: slot_byte = s.idx_x;
			SLOT_A: slot_byte = s.acc;
			SLOT_CC: slot_byte = s.flags;
			default: slot_byte = s.idx_y;
		endcase
	endfunction
	// arithmetic, logic and shift unit on the accumulator
	function automatic logic [9:0] alu_calc(input crr_op_e op, input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] sum;
		sum = 9'h000;
		case (op)
			OP_ADD, OP_ADC: begin
				sum = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == OP_ADC)};
				alu_calc = {sum[4] ^ a[4] ^ b[4], sum}; // carry out of bit 3
			end
			OP_SUB, OP_SBC: begin
				sum = {1'b0, a} - {1'b0, b} - {8'h00, cin & (op == OP_SBC)};
				alu_calc = {1'b0, sum}; // borrow lands in the carry
			end
			OP_AND: alu_calc = {1'b0, cin, a & b};
			OP_OR: alu_calc = {1'b0, cin, a | b};
			OP_XOR: alu_calc = {1'b0, cin, a ^ b};
			OP_SHL: alu_calc = {1'b0, a[7], a[6:0], 1'b0};
			OP_SHR: alu_calc = {1'b0, a[0], 1'b0, a[7:1]};
			OP_ROL: alu_calc = {1'b0, a[7], a[6:0], cin};
			OP_ROR: alu_calc = {1'b0, a[0], cin, a[7:1]};
			default: alu_calc = {1'b0, cin, a};
		endcase
	endfunction
	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// new operations only while idle; no memory-mapped access exists
	assign accept = op_valid_i && (r_reg.st == ST_IDLE);
	assign alu = alu_calc(op_code_i, r_reg.acc, op_data_i, r_reg.flags[FLAG_C]);
	// decode, sequence and stack pointer arithmetic
	always_comb begin
		r_next = r_reg;
		{r_next.stk_we, r_next.stk_re} = 2'b00; // strobes last one cycle
		{push_now, pop_now} = 2'b00;
		slot_go = r_reg.slot;
		case (r_reg.st)
			ST_IDLE: begin
				if (accept) begin
					case (op_code_i)
						// data move into a register
						OP_LOAD: begin
							case (op_sel_i)
								SEL_A: r_next.acc = op_data_i;
								SEL_X: r_next.idx_x = op_data_i;
								SEL_Y: r_next.idx_y = op_data_i;
								default: r_next.flags = fix_flags(op_data_i);
							endcase
							if (op_sel_i != SEL_CC) begin
								{r_next.flags[FLAG_N], r_next.flags[FLAG_Z]} = nz_of(op_data_i);
							end
						end
						// accumulator arithmetic and logic
						OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
						OP_SHL, OP_SHR, OP_ROL, OP_ROR: begin
							r_next.acc = alu[7:0];
							{r_next.flags[FLAG_N], r_next.flags[FLAG_Z]} = nz_of(alu[7:0]);
							r_next.flags[FLAG_C] = alu[8];
							if (op_code_i == OP_ADD || op_code_i == OP_ADC) r_next.flags[FLAG_H] = alu[9];
						end
						// bit test copies the tested bit into carry
						OP_BTJ: r_next.flags[FLAG_C] = op_data_i[op_bit_i];
						OP_SCF: r_next.flags[FLAG_C] = 1'b1;
						OP_RCF: r_next.flags[FLAG_C] = 1'b0;
						// priority changes by instruction
						OP_RIM, OP_WAIT: {r_next.flags[FLAG_I1], r_next.flags[FLAG_I0]} = PRIO_LEVEL0;
						OP_SIM: {r_next.flags[FLAG_I1], r_next.flags[FLAG_I0]} = PRIO_LEVEL3;
						// single flag bit control
						OP_FLAG_BIT: begin
							r_next.flags[op_bit_i] = op_data_i[0];
							r_next.flags = fix_flags(r_next.flags);
						end
						// single byte push or pop
						OP_PUSH: begin
							push_now = 1'b1;
							slot_go = sel_slot(op_sel_i);
							r_next.last = slot_go;
							r_next.fin_ip = 1'b0;
							r_next.fin_prio = 1'b0;
						end
						OP_POP: begin
							pop_now = 1'b1;
							slot_go = sel_slot(op_sel_i);
							r_next.last = slot_go;
						end
						OP_RSP: r_next.sp_low = SP_LOW_RESET;
						OP_LD_S: r_next.sp_low = op_data_i;
						OP_JUMP: r_next.ip = op_addr_i;
						OP_STEP: r_next.ip = r_reg.ip + {8'h00, op_data_i};
						// call: two return bytes then jump
						OP_CALL: begin
							push_now = 1'b1;
							slot_go = SLOT_PCL;
							r_next.last = SLOT_PCH;
							r_next.tgt = op_addr_i;
							r_next.fin_ip = 1'b1;
							r_next.fin_prio = 1'b0;
						end
						OP_RET: begin
							pop_now = 1'b1;
							slot_go = SLOT_PCH;
							r_next.last = SLOT_PCL;
						end
						// interrupt entry: five byte frame, y left alone
						OP_IRQ: begin
							push_now = 1'b1;
							slot_go = SLOT_PCL;
							r_next.last = SLOT_CC;
							r_next.tgt = op_addr_i;
							r_next.prio = irq_level_i;
							r_next.fin_ip = 1'b1;
							r_next.fin_prio = 1'b1;
						end
						OP_IRQ_RETURN_OP: begin
							pop_now = 1'b1;
							slot_go = SLOT_CC;
							r_next.last = SLOT_PCL;
						end
						default: r_next = r_next;
					endcase
				end
			end
			ST_PUSH: push_now = 1'b1; // continue a push sequence
			// capture the byte read this cycle, then read the next
			ST_POP: begin
				case (r_reg.slot)
					SLOT_PCL: r_next.ip[7:0] = stk_rdata_i;
					SLOT_PCH: r_next.ip[15:8] = stk_rdata_i;
					SLOT_X: r_next.idx_x = stk_rdata_i;
					SLOT_A: r_next.acc = stk_rdata_i;
					SLOT_CC: r_next.flags = fix_flags(stk_rdata_i);
					default: r_next.idx_y = stk_rdata_i;
				endcase
				r_next.st = ST_IDLE;
				if (r_reg.slot != r_reg.last) begin
					pop_now = 1'b1;
					slot_go = r_reg.slot - 3'h1;
				end
			end
			default: r_next.st = ST_IDLE;
		endcase
		// write at the free location, then step down with wrap
		if (push_now) begin
			r_next.stk_we = 1'b1;
			r_next.stk_addr = {SP_HIGH, r_reg.sp_low};
			r_next.stk_wdata = slot_byte(r_reg, slot_go);
			r_next.sp_low = r_reg.sp_low - 8'h01;
			if (slot_go == r_next.last) begin
				r_next.st = ST_IDLE;
				if (r_next.fin_ip) r_next.ip = r_next.tgt;
				if (r_next.fin_prio) {r_next.flags[FLAG_I1], r_next.flags[FLAG_I0]} = r_next.prio;
			end else begin
				r_next.slot = slot_go + 3'h1;
				r_next.st = ST_PUSH;
			end
		end
		// step up with wrap, then read
		if (pop_now) begin
			r_next.stk_re = 1'b1;
			r_next.sp_low = r_reg.sp_low + 8'h01;
			r_next.stk_addr = {SP_HIGH, r_reg.sp_low + 8'h01};
			r_next.slot = slot_go;
			r_next.st = ST_POP;
		end
		r_next.busy = (r_next.st != ST_IDLE);
	end
	// state register, synchronous reset to the values after reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r_reg <= '{acc: DATA_RESET, idx_x: DATA_RESET, idx_y: DATA_RESET, ip: IP_RESET,
				flags: FLAG_RESET, sp_low: SP_LOW_RESET, st: ST_IDLE, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end
	// outputs straight from the state register
	assign stk_addr_o = r_reg.stk_addr;
	assign stk_wdata_o = r_reg.stk_wdata;
	assign stk_we_o = r_reg.stk_we;
	assign stk_re_o = r_reg.stk_re;
	assign acc_o = r_reg.acc;
	assign idx_x_o = r_reg.idx_x;
	assign idx_y_o = r_reg.idx_y;
	assign instr_pointer_o = r_reg.ip;
	assign flag_word_o = r_reg.flags;
	assign stack_ptr_o = {SP_HIGH, r_reg.sp_low};
	assign busy_o = r_reg.busy;
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// five consecutive frame writes, then quiet
	sequence irq_frame_s;
		stk_we_o [*5] ##1 !stk_we_o;
	endsequence
	// first frame byte is pcl at the old pointer
	sequence pcl_first_s;
		stk_we_o && stk_wdata_o == $past(instr_pointer_o[7:0]) && stk_addr_o == $past(stack_ptr_o);
	endsequence
	sp_high_fixed_a: assert property (stack_ptr_o[15:8] == SP_HIGH)
		else $error("stack pointer upper byte not fixed");
	sp_reset_top_a: assert property ($past(rst_i) |-> stack_ptr_o == SP_RESET)
		else $error("stack pointer not at top after reset");
	push_step_a: assert property (accept && op_code_i == OP_PUSH |=>
		stack_ptr_o[7:0] == $past(stack_ptr_o[7:0]) - 8'h01 && stk_addr_o == $past(stack_ptr_o))
		else $error("push did not write then decrement");
	irq_frame_a: assert property (accept && op_code_i == OP_IRQ |=> pcl_first_s and irq_frame_s)
		else $error("interrupt frame wrong");
	irq_keeps_y_a: assert property (accept && op_code_i == OP_IRQ |=> $stable(idx_y_o) [*6])
		else $error("index y changed on interrupt entry");
	irq_prio_load_a: assert property (accept && op_code_i == OP_IRQ |-> ##5
		{flag_word_o[FLAG_I1], flag_word_o[FLAG_I0]} == $past(irq_level_i, 5))
		else $error("priority not loaded on interrupt entry");
	load_nz_a: assert property (accept && op_code_i == OP_LOAD && op_sel_i == SEL_A |=>
		flag_word_o[FLAG_Z] == ($past(op_data_i) == 8'h00) && flag_word_o[FLAG_N] == $past(op_data_i[7]))
		else $error("negative or zero flag wrong after load");
	add_half_a: assert property (accept && op_code_i == OP_ADD |=>
		flag_word_o[FLAG_H] == ($past({1'b0, acc_o[3:0]} + {1'b0, op_data_i[3:0]}) >= 5'h10))
		else $error("half carry wrong after add");
	carry_set_a: assert property (accept && op_code_i == OP_SCF |=> flag_word_o[FLAG_C])
		else $error("carry not set");
	fixed_bits_a: assert property (flag_word_o[7:6] == 2'b11)
		else $error("flag word bits 7:6 not one");
endmodule

// ### rtl/crr_pkg.sv
// package of constants and types for the cpu core register set
package crr_pkg;

	// ---------------------------------------------------------------
	// flag word bit positions
	// ---------------------------------------------------------------
	localparam int FLAG_C = 0; // carry / borrow
	localparam int FLAG_Z = 1; // zero
	localparam int FLAG_N = 2; // negative
	localparam int FLAG_I0 = 3; // priority_bit_lo
	localparam int FLAG_H = 4; // half carry
	localparam int FLAG_I1 = 5; // priority_bit_hi

	// ---------------------------------------------------------------
	// reset values and fixed patterns
	// ---------------------------------------------------------------
	localparam logic [7:0] FLAG_RESET = 8'he8; // 111x1xxx with x taken as 0
	localparam logic [7:0] FLAG_FIXED = 8'hc0; // bits 7:6 always one
	localparam logic [7:0] SP_HIGH = 8'h01; // forced upper byte of stack_ptr
	localparam logic [7:0] SP_LOW_RESET = 8'hff; // top of stack
	localparam logic [15:0] SP_RESET = 16'h01ff; // full stack_ptr after reset
	localparam logic [15:0] IP_RESET = 16'h0000; // instr_pointer after reset
	localparam logic [7:0] DATA_RESET = 8'h00; // accumulator and index registers

	// ---------------------------------------------------------------
	// software priority codes, {priority_bit_hi, priority_bit_lo}
	// ---------------------------------------------------------------
	localparam logic [1:0] PRIO_LEVEL0 = 2'b10; // main
	localparam logic [1:0] PRIO_LEVEL1 = 2'b01;
	localparam logic [1:0] PRIO_LEVEL2 = 2'b00;
	localparam logic [1:0] PRIO_LEVEL3 = 2'b11; // interrupts disabled

	// ---------------------------------------------------------------
	// stack frame slots, in push order
	// ---------------------------------------------------------------
	localparam logic [2:0] SLOT_PCL = 3'h0;
	localparam logic [2:0] SLOT_PCH = 3'h1;
	localparam logic [2:0] SLOT_X = 3'h2;
	localparam logic [2:0] SLOT_A = 3'h3;
	localparam logic [2:0] SLOT_CC = 3'h4;
	localparam logic [2:0] SLOT_Y = 3'h5;

	// micro operations issued by the instruction sequencer
	typedef enum logic [4:0] {
		OP_NOP, OP_LOAD, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
		OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_BTJ, OP_SCF, OP_RCF, OP_RIM, OP_SIM,
		OP_WAIT, OP_FLAG_BIT, OP_PUSH, OP_POP, OP_RSP, OP_LD_S, OP_JUMP, OP_STEP,
		OP_CALL, OP_RET, OP_IRQ, OP_IRQ_RETURN_OP
	} crr_op_e;

	// register selector for load, push and pop
	typedef enum logic [1:0] {SEL_A, SEL_X, SEL_Y, SEL_CC} crr_sel_e;

	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} crr_state_e;

endpackage

// ### sim/tb_top.sv
// self-checking bench for the cpu core register set, with a reference model of the registers
`timescale 1ns/1ps
module tb_top;
	import crr_pkg::*;

	// ---------------------------------------------------------------
	// design signals
	// ---------------------------------------------------------------
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic op_valid_i = 1'b0;
	crr_op_e op_code_i = OP_NOP;
	crr_sel_e op_sel_i = SEL_A;
	logic [2:0] op_bit_i = 3'h0;
	logic [7:0] op_data_i = 8'h00;
	logic [15:0] op_addr_i = 16'h0000;
	logic [1:0] irq_level_i = 2'b00;
	logic [7:0] stk_rdata_i;
	logic [15:0] stk_addr_o, instr_pointer_o, stack_ptr_o;
	logic [7:0] stk_wdata_o, acc_o, idx_x_o, idx_y_o, flag_word_o;
	logic stk_we_o, stk_re_o, busy_o;

	// ---------------------------------------------------------------
	// bench state and reference model
	// ---------------------------------------------------------------
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h0000_003b; // xorshift start
	logic [7:0] mem [0:255]; // stack ram seen by the design
	logic [7:0] mm [0:255]; // stack ram of the model
	logic [23:0] wq [$]; // writes seen: addr, data
	logic [23:0] eq [$]; // writes expected
	logic [7:0] ma, mx, my, mf, msp;
	logic [15:0] mip;
	int npush, npop;

	crr_core_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
		.op_sel_i(op_sel_i), .op_bit_i(op_bit_i), .op_data_i(op_data_i), .op_addr_i(op_addr_i),
		.irq_level_i(irq_level_i), .stk_addr_o(stk_addr_o), .stk_wdata_o(stk_wdata_o), .stk_we_o(stk_we_o),
		.stk_re_o(stk_re_o), .stk_rdata_i(stk_rdata_i), .acc_o(acc_o), .idx_x_o(idx_x_o), .idx_y_o(idx_y_o),
		.instr_pointer_o(instr_pointer_o), .flag_word_o(flag_word_o), .stack_ptr_o(stack_ptr_o), .busy_o(busy_o));

	// 50 mhz clock
	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// ram answers only during a read strobe, otherwise shows garbage
	assign stk_rdata_i = stk_re_o ? mem[stk_addr_o[7:0]] : ~mem[stk_addr_o[7:0]];

	// ram write and write log, taken mid-cycle so the last strobe is seen
	always @(negedge ref_clk_i) begin
		if (stk_we_o === 1'b1) begin
			mem[stk_addr_o[7:0]] = stk_wdata_o;
			wq.push_back({stk_addr_o, stk_wdata_o});
		end
	end

	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic report(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// register contents
	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
		report({8'h00, got}, {8'h00, exp});
	endtask

	// flag word
	task automatic cmp_flag(input logic [7:0] got, input logic [7:0] exp);
		report({16'h0000, got}, {16'h0000, exp});
	endtask

	// one stack write
	task automatic cmp_wr(input logic [23:0] got, input logic [23:0] exp);
		report(got, exp);
	endtask

	task automatic mpush(input logic [7:0] d);
		eq.push_back({SP_HIGH, msp, d});
		mm[msp] = d;
		msp = msp - 8'h01;
		npush++;
	endtask

	task automatic mpop(output logic [7:0] d);
		msp = msp + 8'h01;
		d = mm[msp];
		npop++;
	endtask

	task automatic nz(input logic [7:0] v);
		mf[FLAG_N] = v[7];
		mf[FLAG_Z] = (v == 8'h00);
	endtask

	// model of one operation
	task automatic mop(input crr_op_e op, input crr_sel_e sel, input logic [2:0] bt, input logic [7:0] d,
		input logic [15:0] ad, input logic [1:0] lv);
		logic [8:0] r;
		logic c;
		logic [7:0] v;
		c = mf[FLAG_C];
		npush = 0;
		npop = 0;
		case (op)
			OP_LOAD: begin
				case (sel)
					SEL_A: ma = d;
					SEL_X: mx = d;
					SEL_Y: my = d;
					default: mf = d | FLAG_FIXED;
				endcase
				if (sel != SEL_CC) nz(d);
			end
			OP_ADD, OP_ADC: begin
				if (op == OP_ADD) c = 1'b0;
				r = {1'b0, ma} + {1'b0, d} + {8'h00, c};
				mf[FLAG_H] = ({1'b0, ma[3:0]} + {1'b0, d[3:0]} + {4'h0, c}) > 5'h0f;
				mf[FLAG_C] = r[8];
				ma = r[7:0];
				nz(ma);
			end
			OP_SUB, OP_SBC: begin
				if (op == OP_SUB) c = 1'b0;
				r = {1'b0, ma} - {1'b0, d} - {8'h00, c};
				mf[FLAG_C] = r[8];
				ma = r[7:0];
				nz(ma);
			end
			OP_AND, OP_OR, OP_XOR: begin
				ma = (op == OP_AND) ? (ma & d) : (op == OP_OR) ? (ma | d) : (ma ^ d);
				nz(ma);
			end
			OP_SHL, OP_SHR, OP_ROL, OP_ROR: begin
				case (op)
					OP_SHL: {mf[FLAG_C], ma} = {ma, 1'b0};
					OP_SHR: {ma, mf[FLAG_C]} = {1'b0, ma};
					OP_ROL: {mf[FLAG_C], ma} = {ma, c};
					default: {ma, mf[FLAG_C]} = {c, ma};
				endcase
				nz(ma);
			end
			OP_BTJ: mf[FLAG_C] = d[bt];
			OP_SCF: mf[FLAG_C] = 1'b1;
			OP_RCF: mf[FLAG_C] = 1'b0;
			OP_RIM, OP_WAIT: {mf[FLAG_I1], mf[FLAG_I0]} = PRIO_LEVEL0;
			OP_SIM: {mf[FLAG_I1], mf[FLAG_I0]} = PRIO_LEVEL3;
			OP_FLAG_BIT: begin
				mf[bt] = d[0];
				mf = mf | FLAG_FIXED;
			end
			OP_PUSH: mpush(sel == SEL_A ? ma : sel == SEL_X ? mx : sel == SEL_Y ? my : mf);
			OP_POP: begin
				mpop(v);
				case (sel)
					SEL_A: ma = v;
					SEL_X: mx = v;
					SEL_Y: my = v;
					default: mf = v | FLAG_FIXED;
				endcase
			end
			OP_RSP: msp = SP_LOW_RESET;
			OP_LD_S: msp = d;
			OP_JUMP: mip = ad;
			OP_STEP: mip = mip + {8'h00, d};
			OP_CALL: begin
				mpush(mip[7:0]);
				mpush(mip[15:8]);
				mip = ad;
			end
			OP_RET: begin
				mpop(mip[15:8]);
				mpop(mip[7:0]);
			end
			OP_IRQ: begin
				mpush(mip[7:0]);
				mpush(mip[15:8]);
				mpush(mx);
				mpush(ma);
				mpush(mf);
				mip = ad;
				{mf[FLAG_I1], mf[FLAG_I0]} = lv;
			end
			OP_IRQ_RETURN_OP: begin
				mpop(v);
				mf = v | FLAG_FIXED;
				mpop(ma);
				mpop(mx);
				mpop(mip[15:8]);
				mpop(mip[7:0]);
			end
			default: ;
		endcase
	endtask

	// compare every register and the stack writes with the model
	task automatic check_all();
		cmp_reg({8'h00, acc_o}, {8'h00, ma});
		cmp_reg({idx_x_o, idx_y_o}, {mx, my});
		cmp_reg(instr_pointer_o, mip);
		cmp_flag(flag_word_o, mf);
		cmp_reg(stack_ptr_o, {SP_HIGH, msp});
		cmp_reg(16'(wq.size()), 16'(eq.size()));
		while (wq.size() > 0 && eq.size() > 0) cmp_wr(wq.pop_front(), eq.pop_front());
		wq.delete();
		eq.delete();
	endtask

	// one operation: request, optional refused request while busy, wait, check
	task automatic do_op(input crr_op_e op, input crr_sel_e sel, input logic [2:0] bt, input logic [7:0] d,
		input logic [15:0] ad, input logic [1:0] lv, input bit poke);
		int nb;
		nb = 0;
		@(posedge ref_clk_i);
		op_valid_i <= 1'b1;
		op_code_i <= op;
		op_sel_i <= sel;
		op_bit_i <= bt;
		op_data_i <= d;
		op_addr_i <= ad;
		irq_level_i <= lv;
		@(posedge ref_clk_i);
		op_valid_i <= 1'b0;
		#1;
		while (busy_o === 1'b1 && nb < 20) begin
			@(posedge ref_clk_i);
			if (poke && nb == 0) begin
				op_valid_i <= 1'b1;
				op_code_i <= OP_LOAD;
				op_sel_i <= SEL_A;
				op_data_i <= 8'h55;
			end else begin
				op_valid_i <= 1'b0;
			end
			#1;
			nb++;
		end
		// the last stack write is logged mid-cycle, so let it land first
		@(negedge ref_clk_i);
		#1;
		mop(op, sel, bt, d, ad, lv);
		cmp_reg(16'(nb), 16'(npop > 0 ? npop : (npush > 0 ? npush - 1 : 0)));
		check_all();
	endtask

	task automatic rnd_op(input crr_op_e op);
		logic [31:0] r;
		r = rnd();
		do_op(op, crr_sel_e'(r[1:0]), r[4:2], r[12:5], r[31:16], r[14:13], 1'b0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
			mm[i] = 8'(i) ^ 8'h5a;
		end
		{ma, mx, my, mip, mf, msp} = {DATA_RESET, DATA_RESET, DATA_RESET, IP_RESET, FLAG_RESET, SP_LOW_RESET};
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		check_all();
		// stack wraps both ways, reload, interrupt with refused request, return
		do_op(OP_LD_S, SEL_A, 3'h0, 8'h00, 16'h0000, 2'b00, 1'b0);
		do_op(OP_LOAD, SEL_A, 3'h0, 8'h9c, 16'h0000, 2'b00, 1'b0);
		do_op(OP_PUSH, SEL_A, 3'h0, 8'h00, 16'h0000, 2'b00, 1'b0);
		do_op(OP_POP, SEL_Y, 3'h0, 8'h00, 16'h0000, 2'b00, 1'b0);
		do_op(OP_LD_S, SEL_A, 3'h0, 8'h40, 16'h0000, 2'b00, 1'b0);
		do_op(OP_RSP, SEL_A, 3'h0, 8'h00, 16'h0000, 2'b00, 1'b0);
		do_op(OP_IRQ, SEL_A, 3'h0, 8'h00, 16'h1234, PRIO_LEVEL1, 1'b1);
		do_op(OP_IRQ_RETURN_OP, SEL_A, 3'h0, 8'h00, 16'h0000, 2'b00, 1'b0);
		// every operation except OP_NOP once, then a random mix without OP_NOP
		for (int k = 1; k < 30; k++) rnd_op(crr_op_e'(k));
		for (int k = 0; k < 400; k++) rnd_op(crr_op_e'(5'(1 + rnd() % 29)));
		results();
	end
endmodule
